// [design/pcf_defines.svh]
// Constants for the program counter and fetch pipeline
// -------------------------------------------------------------------
// -------------------------------------------------------------------
`ifndef PCF_DEFINES_SVH
`define PCF_DEFINES_SVH

`define PC_W          21
`define PCW_W         20
`define INSTR_W       16
`define OPND_W        12
`define OFFS_W        11
`define BYTE_W        8
`define PCW_RESET     20'h00000
`define PC_STEP_W     20'h00001
`define EXT_PREFIX    4'hf
`define PH_ONE        2'h0
`define PH_TWO        2'h1
`define PH_THREE      2'h3
`define PH_FOUR       2'h2
`define PH_COUNT      4

`endif

// [design/pcf_pkg.sv]
// Types shared by the fetch pipeline files
`include "pcf_defines.svh"

package pcf_pkg;

    // Gray-coded phase sequence one, two, three, four
    typedef enum logic [1:0] {
        PH_ONE   = `PH_ONE,
        PH_TWO   = `PH_TWO,
        PH_THREE = `PH_THREE,
        PH_FOUR  = `PH_FOUR
    } phase_t;

    // Requests from the execute unit for the word now executing
    typedef enum logic [3:0] {
        OP_NONE      = 4'h0,
        OP_JUMP_ABS  = 4'h1,
        OP_CALL_ABS  = 4'h2,
        OP_BRANCH    = 4'h3,
        OP_CALL_REL  = 4'h4,
        OP_INT_ACK   = 4'h5,
        OP_SKIP      = 4'h6,
        OP_PCL_READ  = 4'h7,
        OP_PCL_WRITE = 4'h8,
        OP_PCL_ADD   = 4'h9,
        OP_HIGH_WR   = 4'ha,
        OP_UPPER_WR  = 4'hb
    } op_t;

    typedef struct packed {
        op_t                    op;
        logic                   two_word;
        logic [`BYTE_W-1:0]     data;
        logic [`PCW_W-1:0]      target;
        logic [`OFFS_W-1:0]     offset;
    } ctrl_t;

    typedef struct packed {
        logic                   valid;
        logic [`INSTR_W-1:0]    word;
        logic                   opnd_valid;
        logic [`OPND_W-1:0]     opnd;
    } exec_t;

endpackage

// [design/phase_gen.sv]
// Four-phase divider of the core clock
`timescale 1ns/100ps
`default_nettype none
`include "pcf_defines.svh"

module phase_gen (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  ce,
    output logic [`PH_COUNT-1:0]       phase
);

    // -------------------------------------------------------------
    // Phase sequencer
    // -------------------------------------------------------------
    pcf_pkg::phase_t state_reg;
    pcf_pkg::phase_t state_next;
    localparam logic [1:0] CODES [`PH_COUNT] =
        '{`PH_ONE, `PH_TWO, `PH_THREE, `PH_FOUR};

    // Gray walk, one bit changes per step
    always_comb begin
        case (state_reg)
            pcf_pkg::PH_ONE:   state_next = pcf_pkg::PH_TWO;
            pcf_pkg::PH_TWO:   state_next = pcf_pkg::PH_THREE;
            pcf_pkg::PH_THREE: state_next = pcf_pkg::PH_FOUR;
            pcf_pkg::PH_FOUR:  state_next = pcf_pkg::PH_ONE;
            default:           state_next = pcf_pkg::PH_ONE;
        endcase
    end

    // Reset parks in phase one so the first cycle is a whole one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pcf_pkg::PH_ONE;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    // One-hot, non-overlapping phase strobes
    genvar i;
    generate
        for (i = 0; i < `PH_COUNT; i++) begin : g_ph
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    phase[i] <= (i == 0);
                end else if (ce) begin
                    phase[i] <= (state_next == CODES[i]);
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// [design/program_counter_fetch_pipeline.sv]
// Program counter, latches and two-stage fetch/execute pipeline
`timescale 1ns/100ps
`default_nettype none
`include "pcf_defines.svh"

module program_counter_fetch_pipeline (
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RST_N_IN,
    input  wire logic                   CE_IN,
    // Program memory fetch port
    output logic [`PC_W-1:0]            PMEM_ADDR_OUT,
    input  wire logic [`INSTR_W-1:0]    PMEM_DATA_IN,
    // Execute unit side
    input  wire pcf_pkg::ctrl_t         CTRL_IN,
    input  wire logic [`BYTE_W-1:0]     WORK_REG_IN,
    output pcf_pkg::exec_t              EXEC_OUT,
    output logic [`PH_COUNT-1:0]        PHASE_OUT,
    output logic                        DMEM_RD_OUT,
    output logic                        DMEM_WR_OUT,
    // Software view of the counter
    output logic [`BYTE_W-1:0]          PCL_OUT,
    output logic [`BYTE_W-1:0]          HIGH_LATCH_OUT,
    output logic [`BYTE_W-1:0]          UPPER_LATCH_OUT,
    // Return stack push
    output logic                        PUSH_OUT,
    output logic [`PC_W-1:0]            PUSH_ADDR_OUT
);

    // -------------------------------------------------------------
    // Overview
    // -------------------------------------------------------------
    // One instruction cycle is four core clocks, phase one to four.
    // Phase one: the fetch address is issued and the counter steps.
    // Phase two: a low byte read snapshots the upper counter bytes.
    // Phase three: nothing is sampled; target arithmetic settles.
    // Phase four: the fetched word lands in the instruction register
    // and the executing word may redirect the counter.
    //
    // The execute unit owns decode. It presents one request per
    // cycle on the control input and holds it for the whole cycle.
    // Requests are ignored while the executing word is a bubble,
    // so a flushed word or a lone second word never steers.
    //
    // The counter is kept as a word address. Bit zero is never
    // stored, so an odd address is impossible by construction
    // rather than prevented by a check that could be bypassed.
    //
    // Hazard: the latches are software state. Only a low byte read
    // refreshes them, so a computed jump with no read first lands
    // wherever the last latch writes pointed.
    //
    // Limitation: a low clock enable freezes the whole pipeline,
    // phases included, so a stall never splits a cycle.

    // -------------------------------------------------------------
    // Decode helpers
    // -------------------------------------------------------------

    // Operations that redirect the fetch stream
    function automatic logic redirects(input pcf_pkg::op_t op);
        case (op)
            pcf_pkg::OP_JUMP_ABS,
            pcf_pkg::OP_CALL_ABS,
            pcf_pkg::OP_BRANCH,
            pcf_pkg::OP_CALL_REL,
            pcf_pkg::OP_INT_ACK,
            pcf_pkg::OP_SKIP,
            pcf_pkg::OP_PCL_WRITE,
            pcf_pkg::OP_PCL_ADD:  redirects = 1'b1;
            default:              redirects = 1'b0;
        endcase
    endfunction

    // Operations that push a return address
    function automatic logic pushes(input pcf_pkg::op_t op);
        case (op)
            pcf_pkg::OP_CALL_ABS,
            pcf_pkg::OP_CALL_REL,
            pcf_pkg::OP_INT_ACK:  pushes = 1'b1;
            default:              pushes = 1'b0;
        endcase
    endfunction

    // Words whose top nibble is all ones are second words
    function automatic logic is_ext(input logic [`INSTR_W-1:0] w);
        is_ext = (w[`INSTR_W-1 -: 4] == `EXT_PREFIX);
    endfunction

    // -------------------------------------------------------------
    // Phase generation
    // -------------------------------------------------------------
    logic [`PH_COUNT-1:0] phase;
    logic                 ph_one;
    logic                 ph_two;
    logic                 ph_four;

    phase_gen u_phase (
        .clk   (CLOCK_IN),
        .rst_n (RST_N_IN),
        .ce    (CE_IN),
        .phase (phase)
    );

    // Qualified strobes; a low enable freezes everything
    assign ph_one  = CE_IN && phase[0];
    assign ph_two  = CE_IN && phase[1];
    assign ph_four = CE_IN && phase[3];
    assign PHASE_OUT = phase;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    // Only bits 20:1 are stored, so bit 0 cannot become one
    logic [`PCW_W-1:0]    pcw_reg;
    logic [`PCW_W-1:0]    pcw_next;
    logic [`PCW_W-1:0]    fetch_w_reg;
    logic [`BYTE_W-1:0]   high_latch_reg;
    logic [`BYTE_W-1:0]   upper_latch_reg;
    logic                 exec_ok;
    logic [`PCW_W-1:0]    rel_target;
    logic [`BYTE_W-1:0]   pcl_sum;
    logic [`PC_W-1:0]     pc_full;

    assign pc_full = {pcw_reg, 1'b0};

    // Only a genuine instruction may steer the counter
    assign exec_ok = EXEC_OUT.valid;

    // -------------------------------------------------------------
    // Target arithmetic
    // -------------------------------------------------------------

    // Offset counts words; in word units it adds directly, which is
    // a byte displacement of twice the offset
    assign rel_target = fetch_w_reg
        + {{(`PCW_W-`OFFS_W){CTRL_IN.offset[`OFFS_W-1]}},
           CTRL_IN.offset};

    // Working register counts bytes; odd sums fall to the even byte
    assign pcl_sum = pc_full[`BYTE_W-1:0] + WORK_REG_IN;

    // -------------------------------------------------------------
    // Next program counter at phase four of an execute cycle
    // -------------------------------------------------------------

    // Absolute targets arrive as word addresses already; relative
    // ones are reckoned from the word in fetch, which is one past
    // the branch. Low byte writes and adds take their upper bits
    // from the latches, never from the live counter, so software
    // can reach any part of the space with one write.
    //
    // A skip keeps the counter where phase one left it: the word
    // in fetch is simply never executed, and the one after it is
    // fetched next as if nothing happened.
    always_comb begin
        pcw_next = pcw_reg;
        case (CTRL_IN.op)
            pcf_pkg::OP_JUMP_ABS,
            pcf_pkg::OP_CALL_ABS,
            pcf_pkg::OP_INT_ACK: begin
                // Word address straight into bits 20:1
                pcw_next = CTRL_IN.target;
            end
            pcf_pkg::OP_BRANCH,
            pcf_pkg::OP_CALL_REL: begin
                pcw_next = rel_target;
            end
            pcf_pkg::OP_SKIP: begin
                // Word now in fetch is dropped; counter already past it
                pcw_next = pcw_reg;
            end
            pcf_pkg::OP_PCL_WRITE: begin
                pcw_next = {upper_latch_reg[`PC_W-17:0],
                            high_latch_reg,
                            CTRL_IN.data[`BYTE_W-1:1]};
            end
            pcf_pkg::OP_PCL_ADD: begin
                // Add is a write of the low byte, so latches load too;
                // they are not refreshed first, software must read
                pcw_next = {upper_latch_reg[`PC_W-17:0],
                            high_latch_reg,
                            pcl_sum[`BYTE_W-1:1]};
            end
            default: begin
                pcw_next = pcw_reg;
            end
        endcase
    end

    // -------------------------------------------------------------
    // Program counter and fetch address
    // -------------------------------------------------------------

    // Phase one issues the fetch and steps the counter by one word;
    // phase four applies a redirect from the executing word
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pcw_reg     <= `PCW_RESET;
            fetch_w_reg <= `PCW_RESET;
        end else if (ph_one) begin
            fetch_w_reg <= pcw_reg;
            pcw_reg     <= pcw_reg + `PC_STEP_W;
        end else if (ph_four && exec_ok) begin
            pcw_reg     <= pcw_next;
        end
    end

    assign PMEM_ADDR_OUT = {fetch_w_reg, 1'b0};

    // -------------------------------------------------------------
    // Latches for the upper counter bytes
    // -------------------------------------------------------------

    // Read of the low byte happens with the operand read in phase two;
    // explicit latch writes land with the destination in phase four
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            high_latch_reg  <= '0;
            upper_latch_reg <= '0;
        end else if (ph_two && exec_ok &&
                     CTRL_IN.op == pcf_pkg::OP_PCL_READ) begin
            high_latch_reg  <= pc_full[15:8];
            upper_latch_reg <= {3'h0, pc_full[`PC_W-1:16]};
        end else if (ph_four && exec_ok) begin
            if (CTRL_IN.op == pcf_pkg::OP_HIGH_WR) begin
                high_latch_reg <= CTRL_IN.data;
            end
            if (CTRL_IN.op == pcf_pkg::OP_UPPER_WR) begin
                // Only five bits exist above bit 15
                upper_latch_reg <= {3'h0, CTRL_IN.data[4:0]};
            end
        end
    end

    assign HIGH_LATCH_OUT  = high_latch_reg;
    assign UPPER_LATCH_OUT = upper_latch_reg;

    // -------------------------------------------------------------
    // Low byte view
    // -------------------------------------------------------------

    // Registered copy of the low byte; bit 0 is always zero
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PCL_OUT <= '0;
        end else if (CE_IN) begin
            PCL_OUT <= {pc_full[`BYTE_W-1:1], 1'b0};
        end
    end

    // -------------------------------------------------------------
    // Instruction register
    // -------------------------------------------------------------

    // Word fetched in this cycle executes next cycle; a redirect in
    // the same phase four turns it into exactly one bubble
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            EXEC_OUT   <= '0;
        end else if (ph_four) begin
            EXEC_OUT.word <= PMEM_DATA_IN;
            // A second word never runs as its own instruction
            EXEC_OUT.valid <= !(exec_ok && redirects(CTRL_IN.op))
                && !is_ext(PMEM_DATA_IN);
            // Operand data is handed over only to its own first word
            EXEC_OUT.opnd_valid <= exec_ok && CTRL_IN.two_word
                && is_ext(PMEM_DATA_IN);
            EXEC_OUT.opnd <= PMEM_DATA_IN[`OPND_W-1:0];
        end
    end

    // -------------------------------------------------------------
    // Data memory strobes
    // -------------------------------------------------------------

    // Set one phase early so each strobe stands through its phase
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            DMEM_RD_OUT <= 1'b0;
            DMEM_WR_OUT <= 1'b0;
        end else if (CE_IN) begin
            DMEM_RD_OUT <= phase[0] && exec_ok;
            DMEM_WR_OUT <= phase[2] && exec_ok;
        end
    end

    // -------------------------------------------------------------
    // Return address push
    // -------------------------------------------------------------

    // Return points past the whole call: the word after its second
    // word for an absolute call, the word in fetch for one-word cases.
    // The stack itself lives elsewhere; this block only offers a
    // strobe one enabled clock long and an address that holds until the next
    // push, so a slow stack may sample the address late.
    always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PUSH_OUT      <= 1'b0;
            PUSH_ADDR_OUT <= '0;
        end else if (CE_IN) begin
            PUSH_OUT <= ph_four && exec_ok
                && pushes(CTRL_IN.op);
            if (ph_four && exec_ok && pushes(CTRL_IN.op)) begin
                if (CTRL_IN.op == pcf_pkg::OP_CALL_ABS) begin
                    PUSH_ADDR_OUT <= pc_full;
                end else begin
                    PUSH_ADDR_OUT <= {fetch_w_reg, 1'b0};
                end
            end
        end
    end

endmodule

`default_nettype wire

// [verif/prog_mem_model.sv]
// Program memory model that answers the fetch port of the pipeline
`timescale 1ns/100ps
`default_nettype none
`include "pcf_defines.svh"

module prog_mem_model (
    input  wire logic [`PC_W-1:0]    addr_in,
    output logic      [`INSTR_W-1:0] data_out
);
    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Always enabled, so the word follows the address with no delay;
    // one word per even byte address, low byte at the even one
    always_comb begin
        data_out = {3'h0, (addr_in > 21'h00007f), addr_in[12:1]};
        // Two two-word pairs, second word carries the extension prefix
        if (addr_in == 21'h000014 || addr_in == 21'h00001c) begin
            data_out = 16'hc123;
        end
        if (addr_in == 21'h000016 || addr_in == 21'h00001e) begin
            data_out = 16'hf456;
        end
    end
endmodule

`default_nettype wire

// [verif/pcf_monitor.sv]
// Port checker for the program counter and fetch pipeline
`timescale 1ns/100ps
`default_nettype none
`include "pcf_defines.svh"

module pcf_monitor (
    input wire logic                  CLOCK_IN,
    input wire logic                  RST_N_IN,
    input wire logic                  CE_IN,
    input wire pcf_pkg::ctrl_t        CTRL_IN,
    input wire logic [`PC_W-1:0]      PMEM_ADDR_OUT,
    input wire pcf_pkg::exec_t        EXEC_OUT,
    input wire logic [`PH_COUNT-1:0]  PHASE_OUT,
    input wire logic                  DMEM_RD_OUT,
    input wire logic                  DMEM_WR_OUT,
    input wire logic [`BYTE_W-1:0]    PCL_OUT,
    input wire logic                  PUSH_OUT
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RST_N_IN);

    // Jump accepted at the edge that closes phase four of a live cycle
    wire logic        jump_taken;
    wire logic [19:0] tgt;
    assign tgt = CTRL_IN.target;
    assign jump_taken = CE_IN && PHASE_OUT[3] && EXEC_OUT.valid
                        && CTRL_IN.op == pcf_pkg::OP_JUMP_ABS;

    AST_PHASE_ROTATE: assert property (CE_IN |=>
        PHASE_OUT == {$past(PHASE_OUT[2:0]), $past(PHASE_OUT[3])})
        else $error("Phase did not rotate");
    AST_PHASE_ONEHOT: assert property ($onehot(PHASE_OUT))
        else $error("Phase not one-hot");
    AST_FREEZE: assert property (!CE_IN |=>
        $stable(PHASE_OUT) && $stable(PMEM_ADDR_OUT))
        else $error("State moved while clock enable low");
    AST_WORD_ALIGN: assert property (
        PMEM_ADDR_OUT[0] == 1'b0 && PCL_OUT[0] == 1'b0)
        else $error("Counter bit zero set");
    AST_FETCH_HOLD: assert property (
        CE_IN && !PHASE_OUT[0] |=> $stable(PMEM_ADDR_OUT))
        else $error("Fetch address moved outside phase one");
    AST_EXEC_HOLD: assert property (
        CE_IN && !PHASE_OUT[3] |=> $stable(EXEC_OUT))
        else $error("Executing word moved mid cycle");
    AST_OPND_READ: assert property (
        DMEM_RD_OUT == (PHASE_OUT[1] && EXEC_OUT.valid))
        else $error("Operand read strobe misplaced");
    AST_DEST_WRITE: assert property (
        DMEM_WR_OUT == (PHASE_OUT[3] && EXEC_OUT.valid))
        else $error("Destination write strobe misplaced");
    AST_JUMP_FLUSH: assert property (jump_taken |=>
        !EXEC_OUT.valid ##1 PMEM_ADDR_OUT == {$past(tgt, 2), 1'b0})
        else $error("Jump target or flush wrong");
    AST_SECOND_WORD: assert property (
        EXEC_OUT.word[15:12] == `EXT_PREFIX |-> !EXEC_OUT.valid)
        else $error("Extension word executed");
    AST_OPND_PAIR: assert property (EXEC_OUT.opnd_valid |->
        !EXEC_OUT.valid && EXEC_OUT.opnd == EXEC_OUT.word[11:0])
        else $error("Operand word pairing wrong");
    AST_PUSH_PULSE: assert property (PUSH_OUT |=> !PUSH_OUT)
        else $error("Push strobe longer than one clock");

    COV_JUMP: cover property (jump_taken);
    COV_OPND: cover property (EXEC_OUT.opnd_valid);
    COV_PUSH: cover property (PUSH_OUT);
    COV_FREEZE: cover property (!CE_IN);
endmodule

bind program_counter_fetch_pipeline pcf_monitor u_mon (
    .CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
    .CTRL_IN(CTRL_IN), .PMEM_ADDR_OUT(PMEM_ADDR_OUT),
    .EXEC_OUT(EXEC_OUT), .PHASE_OUT(PHASE_OUT),
    .DMEM_RD_OUT(DMEM_RD_OUT), .DMEM_WR_OUT(DMEM_WR_OUT),
    .PCL_OUT(PCL_OUT), .PUSH_OUT(PUSH_OUT));

`default_nettype wire

// [verif/program_counter_fetch_pipeline_tb_top.sv]
// Self-checking bench for the program counter and fetch pipeline
`timescale 1ns/100ps
`default_nettype none
`include "pcf_defines.svh"

module program_counter_fetch_pipeline_tb_top;
    logic                 clk;
    logic                 rst_n;
    logic                 ce;
    logic [`PC_W-1:0]     pmem_addr;
    logic [`INSTR_W-1:0]  pmem_data;
    pcf_pkg::ctrl_t       ctrl;
    logic [`BYTE_W-1:0]   work;
    pcf_pkg::exec_t       ex;
    logic [`PH_COUNT-1:0] phase;
    logic [`BYTE_W-1:0]   pc_low_byte;
    logic [`BYTE_W-1:0]   hi_latch;
    logic [`BYTE_W-1:0]   up_latch;
    logic                 push;
    logic [`PC_W-1:0]     push_addr;
    logic [`PC_W-1:0]     fa;
    logic [`PC_W-1:0]     ea;
    int                   failures;
    int                   n_checks;
    int                   pushes = 0;

    program_counter_fetch_pipeline dut (
        .CLOCK_IN(clk), .RST_N_IN(rst_n), .CE_IN(ce),
        .PMEM_ADDR_OUT(pmem_addr), .PMEM_DATA_IN(pmem_data),
        .CTRL_IN(ctrl), .WORK_REG_IN(work), .EXEC_OUT(ex),
        .PHASE_OUT(phase), .DMEM_RD_OUT(), .DMEM_WR_OUT(), .PCL_OUT(pc_low_byte),
        .HIGH_LATCH_OUT(hi_latch), .UPPER_LATCH_OUT(up_latch),
        .PUSH_OUT(push), .PUSH_ADDR_OUT(push_addr));

    prog_mem_model pm (.addr_in(pmem_addr), .data_out(pmem_data));

    // ----------------------------------------------------------------
    // Clock, watchdog and shared tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Count push strobes; a one-clock pulse is missed by phase sampling
    always @(posedge clk) begin
        if (push === 1'b1) pushes <= pushes + 1;
    end

    // Whole run is about 180 clocks; allow over three times that
    initial begin
        #60000;
        failures++;
        wrap_up();
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [`INSTR_W-1:0] ew(input logic [`PC_W-1:0] a);
        ew = {3'h0, (a > 21'h00007f), a[12:1]};
        if (a == 21'h000014 || a == 21'h00001c) ew = 16'hc123;
        if (a == 21'h000016 || a == 21'h00001e) ew = 16'hf456;
    endfunction

    // Present one request for the next execute cycle, then check the
    // executing word and the address now fetched (nf)
    task automatic op(input pcf_pkg::op_t o, input logic [19:0] t,
                      input logic [7:0] d, input logic tw,
                      input logic ev, input logic [`PC_W-1:0] nf);
        pcf_pkg::ctrl_t c;
        c = '0;
        c.op = o;
        c.target = t;
        c.offset = t[10:0];
        c.data = d;
        c.two_word = tw;
        do @(negedge clk); while (phase[3] !== 1'b1);
        @(posedge clk);
        ctrl <= c;
        work <= d;
        @(posedge clk);
        @(negedge clk);
        ea = fa;
        fa = nf;
        chk("valid", 32'(ev), 32'(ex.valid));
        chk("fetch address", 32'(nf), 32'(pmem_addr));
        if (ev) chk("word", 32'(ew(ea)), 32'(ex.word));
    endtask

    task automatic run(input int k);
        repeat (k) op(pcf_pkg::OP_NONE, 0, 0, 0, 1, fa + 21'h000002);
    endtask

    task automatic latches(input logic [7:0] h, input logic [7:0] u);
        chk("high latch", 32'(h), 32'(hi_latch));
        chk("upper latch", 32'(u), 32'(up_latch));
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk("reset address", 32'h0, 32'(pmem_addr));
        chk("reset phase", 32'h1, 32'(phase));
        @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // Sequential stepping, then a pair taken whole and a pair split
    task automatic t_two_word();
        run(10);
        op(pcf_pkg::OP_NONE, 0, 0, 1, 1, 21'h000016);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h000018);
        chk("operand flag", 32'h1, 32'(ex.opnd_valid));
        chk("operand", 32'h456, 32'(ex.opnd));
        op(pcf_pkg::OP_NONE, 0, 0, 0, 1, 21'h00001a);
        op(pcf_pkg::OP_SKIP, 0, 0, 0, 1, 21'h00001c);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h00001e);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h000020);
        chk("lone second word", 32'h0, 32'(ex.opnd_valid));
        run(1);
    endtask

    // Latches loaded, then a jump and a backward branch ignore them
    task automatic t_jump();
        op(pcf_pkg::OP_HIGH_WR, 0, 8'h5a, 0, 1, 21'h000024);
        op(pcf_pkg::OP_UPPER_WR, 0, 8'h07, 0, 1, 21'h000026);
        op(pcf_pkg::OP_JUMP_ABS, 20'h00020, 0, 0, 1, 21'h000028);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h000040);
        latches(8'h5a, 8'h07);
        run(1);
        op(pcf_pkg::OP_BRANCH, 20'h007fd, 0, 0, 1, 21'h000044);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h00003e);
        run(1);
    endtask

    // Low byte write, read then add: a computed jump
    task automatic t_computed();
        op(pcf_pkg::OP_PCL_WRITE, 0, 8'h41, 0, 1, 21'h000042);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h075a40);
        chk("low byte", 32'h40, 32'(pc_low_byte));
        op(pcf_pkg::OP_HIGH_WR, 0, 8'h33, 0, 1, 21'h075a42);
        op(pcf_pkg::OP_UPPER_WR, 0, 8'h01, 0, 1, 21'h075a44);
        op(pcf_pkg::OP_PCL_READ, 0, 0, 0, 1, 21'h075a46);
        op(pcf_pkg::OP_PCL_ADD, 0, 8'h0b, 0, 1, 21'h075a48);
        latches(8'h5a, 8'h07);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h075a54);
        run(1);
    endtask

    task automatic t_push();
        op(pcf_pkg::OP_CALL_REL, 20'h00002, 0, 0, 1, 21'h075a58);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h075a5c);
        chk("push address", 32'h075a58, 32'(push_addr));
        chk("push count", 32'h1, 32'(pushes));
        op(pcf_pkg::OP_CALL_ABS, 20'h00030, 0, 1, 1, 21'h075a5e);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h000060);
        chk("call push", 32'h075a60, 32'(push_addr));
        op(pcf_pkg::OP_INT_ACK, 20'h00010, 0, 0, 1, 21'h000062);
        op(pcf_pkg::OP_NONE, 0, 0, 0, 0, 21'h000020);
        chk("ack push", 32'h000062, 32'(push_addr));
        chk("push total", 32'h3, 32'(pushes));
    endtask

    // Clock enable low for four clocks holds the phase strobes
    task automatic t_freeze();
        logic [`PH_COUNT-1:0] p;
        @(posedge clk);
        ce <= 1'b0;
        @(negedge clk);
        p = phase;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk("frozen phase", 32'(p), 32'(phase));
        @(posedge clk);
        ce <= 1'b1;
        run(2);
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        ctrl = '0;
        work = 8'h00;
        fa = 21'h000000;
        ea = 21'h000000;
        failures = 0;
        n_checks = 0;
        t_reset();
        t_two_word();
        t_jump();
        t_computed();
        t_push();
        t_freeze();
        wrap_up();
    end
endmodule

`default_nettype wire
